/* File: pkg/serial_port_regs.vh */
// How it works
// R1 - command byte writable only, never read
// R2 - host starts each transaction with command
// R3 - latest command picks direction and register
// R4 - idle after transfer, power-up and reset
// R5 - 32 high input bits reset everything; result register keeps its value
// R6 - command shifted msb first
// R7 - first bit zero gates command load
// R8 - bit 6 zero writes, one reads
// R9 - bits 5..3 address the register
// R10 - address zero: command write, status read
// R11 - widths 16, 8, or 16/24 bits
// R12 - bit 2 on data: continuous readout
// R13 - host enters continuous with 01011100
// R14 - host exits with 01011000 while ready low
// R15 - continuous mode watches input, still resets
// R16 - host keeps input low in continuous mode
// R17 - host writes zeros into bits 1,0
// R18 - command bits clear after reset
// R19 - output pin low signals new result
// R20 - status read by address zero, msb first
// R21 - sample rising, drive falling serial edge
// R22 - read shifts exactly register width then idle
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
`define ADDR_CMD_STATUS 3'h0
`define ADDR_MODE       3'h1
`define ADDR_SETUP      3'h2
`define ADDR_RESULT     3'h3
`define ADDR_IDENT      3'h4
`define ADDR_PINCTL     3'h5
`define ADDR_ZERO_CAL   3'h6
`define ADDR_GAIN_CAL   3'h7
`define CMD_GATE_BIT    7
`define CMD_DIR_BIT     6
`define CMD_SEL_HI      5
`define CMD_SEL_LO      3
`define CMD_CONT_BIT    2
`define CMD_RESET_VAL   8'h00
`define MODE_RESET_VAL  16'h000A
`define FLAGS_RESET_VAL 8'h80
`define RESYNC_ONES     6'h20
`define CONT_EXIT_CMD   8'h58
`endif

/* File: core/pin_sync.v */
`timescale 1ns/1ns
module pin_sync #(
  parameter [0:0] IDLE_LEVEL = 1'b0
) (
  input  wire ref_clk_in,
  input  wire sys_rst_in,
  input  wire pin_in,
  output reg  level_out
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      // start at the pin's idle level so reset release shows no false edge
      s1_r      <= IDLE_LEVEL;
      s2_r      <= IDLE_LEVEL;
      s3_r      <= IDLE_LEVEL;
      level_out <= IDLE_LEVEL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_out <= s3_r;
    end
  end
endmodule

/* File: core/reg_width.v */
`timescale 1ns/1ns
`include "serial_port_regs.vh"
module reg_width #(
  parameter WIDE = 1
) (
  input  wire [2:0] sel_in,
  output reg  [4:0] bits_out
);
  // [R11]
  always @* begin
    case (sel_in)
      `ADDR_CMD_STATUS: bits_out = 5'h08;
      `ADDR_MODE:       bits_out = 5'h10;
      `ADDR_SETUP:      bits_out = 5'h10;
      `ADDR_IDENT:      bits_out = 5'h08;
      `ADDR_PINCTL:     bits_out = 5'h08;
      default:          bits_out = WIDE ? 5'h18 : 5'h10;
    endcase
  end
endmodule

/* File: core/serial_register_access_port.v */
`timescale 1ns/1ns
`include "serial_port_regs.vh"
module serial_register_access_port #(
  parameter       WIDE       = 1,
  parameter [7:0] IDENT_CODE = 8'h5A
) (
  input  wire        ref_clk_in,
  input  wire        sys_rst_in,
  input  wire        sclk_in,
  input  wire        din_in,
  output reg         dout_rdy_out,
  input  wire        result_valid_in,
  input  wire [23:0] result_in,
  input  wire [7:0]  flags_in,
  output reg  [15:0] operating_mode_out,
  output reg  [15:0] channel_setup_out,
  output reg  [7:0]  pin_and_current_control_out,
  output reg  [23:0] zero_calibration_out,
  output reg  [23:0] gain_calibration_out,
  output reg  [7:0]  command_byte_out,
  output reg         continuous_out,
  output reg         part_reset_out
);
  // ident value is arbitrary
  localparam ST_IDLE = 2'h0;
  localparam ST_CMD  = 2'h1;
  localparam ST_WR   = 2'h2;
  localparam ST_RD   = 2'h3;

  wire       sclk_s;
  wire       din_s;
  wire [4:0] sel_bits;
  reg        sclk_d_r;
  reg  [1:0] state_r;
  reg  [4:0] cnt_r;
  reg  [5:0] ones_r;
  reg  [6:0] cmd_sh_r;
  reg  [23:0] sh_r;
  reg  [23:0] result_r;
  reg        rdy_n_r;
  reg        cont_r;

  ////////////////////////////////////////////////////////////////
  // serial clock idles high
  pin_sync #(.IDLE_LEVEL(1'b1)) u_sclk (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (sclk_in),
    .level_out  (sclk_s)
  );
  pin_sync u_din (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (din_in),
    .level_out  (din_s)
  );
  reg_width #(.WIDE(WIDE)) u_width (
    .sel_in   (command_byte_out[`CMD_SEL_HI:`CMD_SEL_LO]),
    .bits_out (sel_bits)
  );

  wire rise = sclk_s & ~sclk_d_r;
  wire fall = ~sclk_s & sclk_d_r;
  wire [2:0] sel = command_byte_out[`CMD_SEL_HI:`CMD_SEL_LO];
  wire [23:0] wr_word = {sh_r[22:0], din_s};

  function [23:0] read_word;
    input [2:0] s;
    begin
      case (s)
        `ADDR_CMD_STATUS: read_word = {rdy_n_r, flags_in[6:0], 16'h0000}; // [R10] [R20]
        `ADDR_MODE:       read_word = {operating_mode_out, 8'h00};
        `ADDR_SETUP:      read_word = {channel_setup_out, 8'h00};
        `ADDR_RESULT:     read_word = result_r;
        `ADDR_IDENT:      read_word = {IDENT_CODE, 16'h0000};
        `ADDR_PINCTL:     read_word = {pin_and_current_control_out, 16'h0000};
        `ADDR_ZERO_CAL:   read_word = zero_calibration_out;
        default:          read_word = gain_calibration_out;
      endcase
    end
  endfunction

  wire [23:0] rd_word = read_word(sel);

  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_d_r                    <= 1'b1;
      state_r                     <= ST_IDLE;
      cnt_r                       <= 5'h00;
      ones_r                      <= 6'h00;
      cmd_sh_r                    <= 7'h00;
      sh_r                        <= 24'h000000;
      result_r                    <= 24'h000000;
      rdy_n_r                     <= 1'b1;
      cont_r                      <= 1'b0;
      dout_rdy_out                <= 1'b1;
      command_byte_out            <= `CMD_RESET_VAL; // [R18]
      continuous_out              <= 1'b0;
      part_reset_out              <= 1'b0;
      operating_mode_out          <= `MODE_RESET_VAL;
      channel_setup_out           <= 16'h0000;
      pin_and_current_control_out <= 8'h00;
      zero_calibration_out        <= 24'h000000;
      gain_calibration_out        <= 24'h000000;
    end else begin
      sclk_d_r       <= sclk_s;
      part_reset_out <= 1'b0;
      continuous_out <= cont_r;
      if (result_valid_in) begin
        result_r <= WIDE ? result_in : {result_in[15:0], 8'h00};
        rdy_n_r  <= 1'b0; // [R19]
      end
      if (state_r == ST_IDLE)
        dout_rdy_out <= rdy_n_r; // [R19]
      if (rise) begin
        // [R5] [R15]
        if (din_s && ones_r == `RESYNC_ONES - 6'h01) begin
          ones_r                      <= 6'h00;
          state_r                     <= ST_IDLE; // [R4]
          command_byte_out            <= `CMD_RESET_VAL;
          cont_r                      <= 1'b0;
          rdy_n_r                     <= 1'b1;
          dout_rdy_out                <= 1'b1;
          part_reset_out              <= 1'b1;
          operating_mode_out          <= `MODE_RESET_VAL;
          channel_setup_out           <= 16'h0000;
          pin_and_current_control_out <= 8'h00;
          zero_calibration_out        <= 24'h000000;
          gain_calibration_out        <= 24'h000000;
        end else begin
          ones_r <= din_s ? ones_r + 6'h01 : 6'h00;
          case (state_r)
            ST_IDLE: begin
              if (!din_s) begin // [R7] [R6]
                state_r <= ST_CMD;
                cnt_r   <= 5'h00;
              end
            end
            ST_CMD: begin
              cmd_sh_r <= {cmd_sh_r[5:0], din_s};
              if (cnt_r == 5'h06) begin
                // [R1] [R3] [R8]
                command_byte_out <= {1'b0, cmd_sh_r[5:0], din_s};
                cnt_r            <= 5'h00;
                if (cmd_sh_r[5]) begin
                  // [R12] continuous readout waits in idle for the ready indication
                  if (cmd_sh_r[4:2] == `ADDR_RESULT && cmd_sh_r[1]) begin
                    state_r <= ST_IDLE;
                    cont_r  <= 1'b1;
                  end else begin
                    state_r <= ST_RD;
                    cont_r  <= 1'b0;
                  end
                end else if (cmd_sh_r[4:2] == `ADDR_CMD_STATUS) begin
                  state_r <= ST_IDLE; // [R10]
                  if (cont_r)
                    cont_r <= 1'b0; // [R15]
                end else begin
                  state_r <= ST_WR;
                end
              end else begin
                cnt_r <= cnt_r + 5'h01;
              end
            end
            ST_WR: begin
              sh_r <= wr_word;
              if (cnt_r == sel_bits - 5'h01) begin
                state_r <= ST_IDLE; // [R4]
                case (sel) // [R9]
                  `ADDR_MODE:     operating_mode_out          <= wr_word[15:0];
                  `ADDR_SETUP:    channel_setup_out           <= wr_word[15:0];
                  `ADDR_PINCTL:   pin_and_current_control_out <= wr_word[7:0];
                  `ADDR_ZERO_CAL: zero_calibration_out        <= WIDE ? wr_word : {wr_word[15:0], 8'h00};
                  `ADDR_GAIN_CAL: gain_calibration_out        <= WIDE ? wr_word : {wr_word[15:0], 8'h00};
                  default: ;
                endcase
              end else begin
                cnt_r <= cnt_r + 5'h01;
              end
            end
            default: begin
              // continuous readout keeps listening for the exit command [R15]
              if (cont_r) begin
                cmd_sh_r <= {cmd_sh_r[5:0], din_s};
                if (cnt_r == 5'h08 && {cmd_sh_r, din_s} == `CONT_EXIT_CMD) begin
                  cont_r           <= 1'b0;
                  command_byte_out <= `CONT_EXIT_CMD;
                end
              end
              // [R22]
              if (cnt_r == sel_bits) begin
                state_r      <= ST_IDLE;
                cnt_r        <= 5'h00;
                dout_rdy_out <= 1'b1;
                // a result arriving in the same cycle keeps ready low
                if (sel == `ADDR_RESULT && !result_valid_in)
                  rdy_n_r <= 1'b1;
              end
            end
          endcase
        end
      end
      if (state_r == ST_RD && rise && cnt_r == 5'h00)
        sh_r <= read_word(sel);
      // [R21] output moves on falling serial edge
      if (fall && state_r == ST_RD && cnt_r < sel_bits) begin
        dout_rdy_out <= (cnt_r == 5'h00) ? rd_word[23] : sh_r[23];
        sh_r         <= (cnt_r == 5'h00) ? {rd_word[22:0], 1'b0} : {sh_r[22:0], 1'b0};
        cnt_r        <= cnt_r + 5'h01;
      end
      // [R12] continuous readout: new result leaves without a command
      if (cont_r && state_r == ST_IDLE && !rdy_n_r && fall) begin
        state_r      <= ST_RD;
        cnt_r        <= 5'h01;
        dout_rdy_out <= result_r[23];
        sh_r         <= {result_r[22:0], 1'b0};
      end
    end
  end
endmodule

/* File: tb/port_monitor.sv */
`timescale 1ns/1ns
module port_monitor (
  input wire        ref_clk_in,
  input wire        sys_rst_in,
  input wire        sclk_in,
  input wire        result_valid_in,
  input wire        dout_rdy_out,
  input wire [15:0] operating_mode_out,
  input wire [7:0]  command_byte_out,
  input wire        continuous_out,
  input wire        part_reset_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_quiet;
    (sclk_in && !result_valid_in) [*8];
  endsequence
  property p_rst; $fell(sys_rst_in) |-> command_byte_out == 8'h00 && dout_rdy_out; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_gate; $changed(command_byte_out) |-> !command_byte_out[7]; endproperty
  a_gate: assert property (p_gate) else $error("gated command loaded");
  property p_cont; $rose(continuous_out) |-> command_byte_out == 8'h5C; endproperty
  a_cont: assert property (p_cont) else $error("bad continuous entry");
  property p_rsync; part_reset_out |-> ##[0:4] (command_byte_out == 8'h00 && !continuous_out); endproperty
  a_rsync: assert property (p_rsync) else $error("no full reset");
  property p_pulse; part_reset_out |=> !part_reset_out; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_hold; s_quiet ##1 (sclk_in && !result_valid_in) |-> $stable(dout_rdy_out); endproperty
  a_hold: assert property (p_hold) else $error("output moved while idle");
  property p_rdy; s_quiet ##1 result_valid_in |-> ##[1:4] !dout_rdy_out; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not shown");
  property p_wsel; $changed(operating_mode_out) |-> command_byte_out[6:3] == 4'h1 || command_byte_out == 8'h00; endproperty
  a_wsel: assert property (p_wsel) else $error("mode written unselected");
endmodule
bind serial_register_access_port port_monitor u_mon (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .sclk_in(sclk_in), .result_valid_in(result_valid_in), .dout_rdy_out(dout_rdy_out),
  .operating_mode_out(operating_mode_out), .command_byte_out(command_byte_out),
  .continuous_out(continuous_out), .part_reset_out(part_reset_out));

/* File: tb/spi_host.sv */
`timescale 1ns/1ns
module spi_host (
  input  wire  ref_clk_in,
  input  wire  dout_rdy_in,
  output logic sclk_out,
  output logic din_out
);
  initial begin
    sclk_out = 1'b1;
    din_out  = 1'b0;
  end
  // msb first, data set at the fall, output taken at the rise; clock idles high
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] got);
    got = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk_in);
      sclk_out <= 1'b0;
      din_out  <= v[i];
      repeat (6) @(posedge ref_clk_in);
      sclk_out <= 1'b1;
      got = {got[30:0], dout_rdy_in};
      repeat (5) @(posedge ref_clk_in);
    end
    @(posedge ref_clk_in);
    din_out <= ~din_out;
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        rv = 1'b0;
  logic [23:0] res = 24'h0;
  logic [7:0]  flags = 8'h05;
  logic        sclk, din, dout, cont, prst, seen = 1'b0;
  logic [15:0] mode, setup;
  logic [7:0]  pinc, cmd;
  logic [23:0] zc, gc;
  logic [31:0] got;
  int          errors = 0;
  int          n_tests = 0;
  // commands keep bits 1..0 at zero
  logic [7:0]  wc [5] = '{8'h08, 8'h10, 8'h28, 8'h30, 8'h38};
  logic [31:0] wv [5] = '{32'hB00F, 32'h1234, 32'h3C, 32'h89ABCD, 32'h13579B};
  int          wn [5] = '{16, 16, 8, 24, 24};
  always #2 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (prst) seen <= 1'b1;
  spi_host host (.ref_clk_in(ref_clk_in), .dout_rdy_in(dout), .sclk_out(sclk), .din_out(din));
  // identity value is arbitrary
  serial_register_access_port #(.WIDE(1), .IDENT_CODE(8'hC3)) dut (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .sclk_in(sclk), .din_in(din), .dout_rdy_out(dout), .result_valid_in(rv),
    .result_in(res), .flags_in(flags), .operating_mode_out(mode), .channel_setup_out(setup),
    .pin_and_current_control_out(pinc), .zero_calibration_out(zc), .gain_calibration_out(gc),
    .command_byte_out(cmd), .continuous_out(cont), .part_reset_out(prst));
  task check(input logic [31:0] a, input logic [31:0] e);
    n_tests++;
    if (a !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  // leading ones ahead of the command exercise the gate
  task xfer(input logic [7:0] c, input logic [31:0] v, input int n);
    host.shift({21'h0, 3'b111, c}, 11, got);
    host.shift(v, n, got);
  endtask
  task pulse(input logic [23:0] r);
    @(posedge ref_clk_in);
    res <= r;
    rv  <= 1'b1;
    @(posedge ref_clk_in);
    rv  <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
  endtask
  task report_and_stop;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    check({cmd, mode, 7'h0, dout}, {8'h00, 16'h000A, 8'h01});
    for (int i = 0; i < 5; i++) begin
      xfer(wc[i], wv[i], wn[i]);
      xfer(wc[i] | 8'h40, 32'h0, wn[i]);
      check(got, wv[i]);
    end
    check({mode, setup}, 32'hB00F1234);
    check({pinc, zc}, 32'h3C89ABCD);
    check(gc, 32'h13579B);
    xfer(8'h60, 32'h0, 8);
    check(got, 32'hC3);
    pulse(24'h5A5A5A);
    xfer(8'h40, 32'h0, 8);
    check(got, 32'h05);
    xfer(8'h58, 32'h0, 24);
    check(got, 32'h5A5A5A);
    repeat (8) @(posedge ref_clk_in);
    check(dout, 1'b1);
    xfer(8'h5C, 32'h0, 0);
    repeat (4) @(posedge ref_clk_in);
    check(cont, 1'b1);
    pulse(24'h2468AC);
    check(dout, 1'b0);
    host.shift(32'h0, 24, got);
    check(got, 32'h2468AC);
    pulse(24'h111111);
    host.shift(32'h580000, 24, got);
    check(got, 32'h111111);
    repeat (8) @(posedge ref_clk_in);
    check({cont, cmd}, {1'b0, 8'h58});
    xfer(8'h5C, 32'h0, 0);
    host.shift(32'hFFFFFFFF, 32, got);
    repeat (8) @(posedge ref_clk_in);
    check({seen, cont, cmd, mode}, {2'b10, 8'h00, 16'h000A});
    report_and_stop();
  end
endmodule
